// ---- logic/urg_rate_gen.v ----
/*
  One channel's fractional rate generator, prescaler and interrupt pin level.
  Assumes the host bus strobes and data arrive already synchronised to clk
  (osc clock); register writes are single-cycle pulses, reads are plain muxes.
*/
// What this block does
// - prescaler divides input clock by 4 when modem control bit 7 set, else 1
// - divisor ranges one to just below 65536 in sixteenth steps
// - sampling pulse paces transmit shifting and receive sampling
// - reset divisor is one: low 01, high 00, fraction 00
// - high byte forms bits 15:8, low byte bits 7:0 of integer divisor
// - fraction register low four bits hold sixteenths
// - fraction bits 5:4 pick sixteen, eight or four samples per bit
// - bit rate is clock over prescale over divisor over oversampling
// - odd fraction at 8x may jitter bit time by a sixteenth
// - host register reads need no oscillator running
// - one oscillator clock feeds both channels' rate generators
// - no fifo: pin low while holding byte, high when empty
// - fifo: pin low above transmit trigger, high below or empty
// - no fifo: pin high with received byte, low with none
// - fifo: pin high above receive trigger, low below
// - fifo control bit 0 picks fifo or plain pin behaviour
`timescale 1ns/1ps
`default_nettype none
`include "urg_consts.vh"

module urg_rate_gen
(
  input  wire       clk,            // oscillator clock shared by both channels
  input  wire       rst,            // asynchronous reset, active high
  input  wire       div_sel,        // address targets divisor registers
  input  wire [2:0] addr,           // host register address
  input  wire       wr_stb,         // one-cycle write pulse
  input  wire [7:0] wr_data,        // host write data
  output reg  [7:0] rd_data,        // host read data, combinational mux
  input  wire       tx_hold_full,   // non-fifo: byte in holding register
  input  wire       tx_empty,       // transmitter wholly empty
  input  wire       tx_above_trig,  // transmit fifo above trigger level
  input  wire       tx_fifo_empty,  // transmit fifo empty
  input  wire       rx_hold_full,   // non-fifo: received byte held
  input  wire       rx_above_trig,  // receive fifo above trigger level
  output reg        sample_tick,    // one-cycle sampling pulse
  output reg  [1:0] oversample,     // selected oversampling code
  output reg        tx_irq_level,   // transmit view of the interrupt pin
  output reg        rx_irq_level    // receive view of the interrupt pin
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  reg  [7:0] divisor_integer_low;
  reg  [7:0] divisor_integer_high;
  reg  [7:0] divisor_fraction_and_oversample;
  reg  [7:0] modem_control_reg;
  reg  [7:0] fifo_control_reg;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      divisor_integer_low             <= `URG_RST_DIV_LOW;
      divisor_integer_high            <= `URG_RST_DIV_HIGH;
      divisor_fraction_and_oversample <= `URG_RST_DIV_FRAC;
      modem_control_reg               <= `URG_RST_CTRL;
      fifo_control_reg                <= `URG_RST_CTRL;
    end
    else if (wr_stb)
    begin
      if (div_sel)
      begin
        if (addr == `URG_ADDR_DIV_LOW)
          divisor_integer_low <= wr_data;
        if (addr == `URG_ADDR_DIV_HIGH)
          divisor_integer_high <= wr_data;
        if (addr == `URG_ADDR_DIV_FRAC)
          divisor_fraction_and_oversample <= wr_data;
      end
      else
      begin
        if (addr == `URG_ADDR_MODEM_CTRL)
          modem_control_reg <= wr_data;
        if (addr == `URG_ADDR_FIFO_CTRL)
          fifo_control_reg <= wr_data;
      end
    end
  end

  // reads are pure muxes of flops, so no clock edge is needed
  always @*
  begin
    rd_data = 8'h00;
    if (div_sel)
    begin
      if (addr == `URG_ADDR_DIV_LOW)
        rd_data = divisor_integer_low;
      else if (addr == `URG_ADDR_DIV_HIGH)
        rd_data = divisor_integer_high;
      else if (addr == `URG_ADDR_DIV_FRAC)
        rd_data = divisor_fraction_and_oversample;
    end
    else if (addr == `URG_ADDR_MODEM_CTRL)
      rd_data = modem_control_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler: clk is the single shared oscillator
  reg  [1:0] pre_cnt;
  wire       pre_tick;
  assign pre_tick = modem_control_reg[`URG_MCR_PRESCALE_BIT] ?
                    (pre_cnt == `URG_PRESCALE_LAST) : 1'b1;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      pre_cnt <= 2'h0;
    else if (pre_tick)
      pre_cnt <= 2'h0;
    else
      pre_cnt <= pre_cnt + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // fractional divider; settings latched only at period end
  wire [15:0] div_int;
  wire [3:0]  div_frac;
  assign div_int  = {divisor_integer_high, divisor_integer_low};
  assign div_frac = divisor_fraction_and_oversample[`URG_FRAC_HI:`URG_FRAC_LO];

  reg  [15:0] per_cnt;
  reg  [15:0] per_len;   // length of the running period in prescaled clocks
  reg  [3:0]  phase;     // position in the sixteen-period pattern
  reg  [4:0]  frac_acc;
  reg  [4:0]  next_frac_acc;
  reg         stretch;   // extra clock on this period
  reg         next_stretch;
  reg  [15:0] next_len;

  // zero divisor is treated as one so the output never stalls
  always @*
  begin
    next_frac_acc = {1'b0, frac_acc[3:0]} + {1'b0, div_frac};
    next_stretch  = next_frac_acc[4];
    next_len      = (div_int == `URG_ZERO16) ? `URG_ONE16 : div_int;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      per_cnt     <= 16'h0000;
      per_len     <= `URG_ONE16;
      phase       <= 4'h0;
      frac_acc    <= 5'h00;
      stretch     <= 1'b0;
      sample_tick <= 1'b0;
      oversample  <= `URG_OSR_16X;
    end
    else
    begin
      sample_tick <= 1'b0;
      if (pre_tick)
      begin
        if (per_cnt + `URG_ONE16 >= per_len && !stretch)
        begin
          // full period done: emit tick, load fresh settings
          sample_tick <= 1'b1;
          per_cnt     <= 16'h0000;
          per_len     <= next_len;
          phase       <= phase + 4'h1;
          frac_acc    <= {1'b0, next_frac_acc[3:0]};
          stretch     <= next_stretch;
          // odd fractions at 8x may land unevenly on bits
          oversample  <= divisor_fraction_and_oversample[`URG_OSR_HI:`URG_OSR_LO];
        end
        else if (per_cnt + `URG_ONE16 >= per_len)
          stretch <= 1'b0;
        else
          per_cnt <= per_cnt + `URG_ONE16;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt pin levels
  wire fifo_en;
  assign fifo_en = fifo_control_reg[`URG_FCR_FIFO_EN_BIT];

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_irq_level <= 1'b1;
      rx_irq_level <= 1'b0;
    end
    else
    begin
      if (fifo_en)
        tx_irq_level <= !(tx_above_trig && !tx_fifo_empty && !tx_empty);
      else
        tx_irq_level <= !tx_hold_full || tx_empty;
      if (fifo_en)
        rx_irq_level <= rx_above_trig;
      else
        rx_irq_level <= rx_hold_full;
    end
  end

endmodule
`default_nettype wire

// ---- logic/urg_consts.vh ----
/*
  Constants for the per-channel rate generator and interrupt pin block.
  Assumes it is included by bare name from the rate generator design file.
*/
`ifndef URG_CONSTS_VH
`define URG_CONSTS_VH

// register offsets on the 3-bit host address
`define URG_ADDR_FIFO_CTRL   3'h2
`define URG_ADDR_MODEM_CTRL  3'h4
`define URG_ADDR_DIV_LOW     3'h0
`define URG_ADDR_DIV_HIGH    3'h1
`define URG_ADDR_DIV_FRAC    3'h2

// reset values
`define URG_RST_DIV_LOW      8'h01
`define URG_RST_DIV_HIGH     8'h00
`define URG_RST_DIV_FRAC     8'h00
`define URG_RST_CTRL         8'h00

// field positions
`define URG_MCR_PRESCALE_BIT 7
`define URG_FCR_FIFO_EN_BIT  0
`define URG_FRAC_HI          3
`define URG_FRAC_LO          0
`define URG_OSR_HI           5
`define URG_OSR_LO           4

// oversampling selections
`define URG_OSR_16X          2'b00
`define URG_OSR_8X           2'b01
`define URG_OSR_4X           2'b10

// prescale count: divide by 4 means terminal count 3
`define URG_PRESCALE_LAST    2'h3
`define URG_PHASE_LAST       4'hf
`define URG_ONE16            16'h0001
`define URG_ZERO16           16'h0000

`endif

// ---- bench/urg_rate_gen_properties.sv ----
/* port checker for urg_rate_gen
   assumes one clock and a bind at the foot of this file */
`timescale 1ns/1ps
`default_nettype none
module urg_props
(
  input wire logic       clk,           // clock
  input wire logic       rst,           // reset
  input wire logic       div_sel,       // bank
  input wire logic [2:0] addr,          // address
  input wire logic       wr_stb,        // write
  input wire logic [7:0] wr_data,       // data in
  input wire logic [7:0] rd_data,       // data out
  input wire logic       tx_hold_full,  // status
  input wire logic       tx_empty,      // status
  input wire logic       tx_above_trig, // status
  input wire logic       tx_fifo_empty, // status
  input wire logic       rx_hold_full,  // status
  input wire logic       rx_above_trig, // status
  input wire logic       sample_tick,   // tick
  input wire logic       tx_irq_level,  // pin, tx
  input wire logic       rx_irq_level   // pin, rx
);
  logic fe;
  logic pe;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of the fifo enable and prescale bits; only fifo control is write-only
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      fe <= 1'b0;
      pe <= 1'b0;
    end
    else if (wr_stb && !div_sel)
    begin
      if (addr == 3'h2) fe <= wr_data[0];
      if (addr == 3'h4) pe <= wr_data[7];
    end
  ////////////////////////////////////////
  a_rx_plain_pin: assert property ($past(!fe) |-> rx_irq_level == $past(rx_hold_full))
    else $error("rx pin wrong with fifo off");
  a_rx_fifo_pin: assert property ($past(fe) |-> rx_irq_level == $past(rx_above_trig))
    else $error("rx pin wrong with fifo on");
  a_tx_plain_pin: assert property ($past(!fe) |->
    tx_irq_level == ($past(!tx_hold_full) || $past(tx_empty)))
    else $error("tx pin wrong with fifo off");
  a_tx_fifo_pin: assert property ($past(fe) |->
    tx_irq_level == !$past(tx_above_trig && !tx_fifo_empty && !tx_empty))
    else $error("tx pin wrong with fifo on");
  a_div_int_write: assert property (wr_stb && div_sel && addr < 3'h2 ##1 $stable(addr) && div_sel
    |-> rd_data == $past(wr_data))
    else $error("integer divisor byte not stored");
  a_frac_bits_write: assert property (wr_stb && div_sel && addr == 3'h2 ##1 div_sel && addr == 3'h2
    |-> rd_data[5:0] == $past(wr_data[5:0]))
    else $error("fraction byte not stored");
  a_fifo_sel_zero: assert property (!div_sel && addr == 3'h2 |-> rd_data == 8'h00)
    else $error("fifo control read not zero");
  a_prescale_gap: assert property (sample_tick && pe && $past(pe) |=> !sample_tick [*3])
    else $error("ticks too close with prescale");
  cover property (sample_tick && pe);
  cover property ($past(fe) && !tx_irq_level);
  cover property (wr_stb && div_sel && addr == 3'h2);
  cover property ($past(!fe) && tx_irq_level && $past(tx_hold_full));
endmodule
bind urg_rate_gen urg_props u_props (.clk(clk), .rst(rst), .div_sel(div_sel), .addr(addr),
  .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data), .tx_hold_full(tx_hold_full),
  .tx_empty(tx_empty), .tx_above_trig(tx_above_trig), .tx_fifo_empty(tx_fifo_empty),
  .rx_hold_full(rx_hold_full), .rx_above_trig(rx_above_trig), .sample_tick(sample_tick),
  .tx_irq_level(tx_irq_level), .rx_irq_level(rx_irq_level));
`default_nettype wire

// ---- bench/urg_host.sv ----
/* host side register access model
   assumes strobes already synchronised to clk */
`timescale 1ns/1ps
`default_nettype none
module urg_host
(
  input  wire logic       clk,     // clock
  input  wire logic [7:0] rd_data, // read data
  output var  logic       div_sel, // bank
  output var  logic [2:0] addr,    // address
  output var  logic       wr_stb,  // write pulse
  output var  logic [7:0] wr_data  // write data
);
  initial
  begin
    div_sel = 1'b0;
    addr = 3'h0;
    wr_stb = 1'b0;
    wr_data = 8'h00;
  end
  // address stays after the pulse, so the next cycle can read it back
  task wr(input logic s, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    div_sel <= s;
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic s, input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    div_sel <= s;
    addr <= a;
    @(posedge clk);
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
/* self-checking bench for urg_rate_gen
   assumes host model and checker compiled first */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [5:0] st = 6'h00;
  logic       div_sel;
  logic [2:0] addr;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic       sample_tick;
  logic [1:0] oversample;
  logic       tx_irq_level;
  logic       rx_irq_level;
  int         num_errors = 0;
  int         checked = 0;
  always #5 clk = ~clk;
  urg_host host (.clk(clk), .rd_data(rd_data), .div_sel(div_sel), .addr(addr),
    .wr_stb(wr_stb), .wr_data(wr_data));
  urg_rate_gen dut (.clk(clk), .rst(rst), .div_sel(div_sel), .addr(addr), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_data(rd_data), .tx_hold_full(st[5]), .tx_empty(st[4]),
    .tx_above_trig(st[3]), .tx_fifo_empty(st[2]), .rx_hold_full(st[1]), .rx_above_trig(st[0]),
    .sample_tick(sample_tick), .oversample(oversample), .tx_irq_level(tx_irq_level),
    .rx_irq_level(rx_irq_level));
  ////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wait_tick;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (sample_tick !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      num_errors++;
      finish_test;
    end
  endtask
  task t_reset;
    logic [7:0] d;
    host.rd(1'b1, 3'h0, d);
    chk(d, 16'h0001);
    host.rd(1'b1, 3'h1, d);
    chk(d, 16'h0000);
    host.rd(1'b1, 3'h2, d);
    chk(d, 16'h0000);
    host.rd(1'b1, 3'h7, d);
    chk(d, 16'h0000);
    chk({tx_irq_level, rx_irq_level}, 16'h0002);
    $display("t_reset done");
  endtask
  // window spans whole stretch patterns, so the tick count is exact
  task t_rate(input logic p, input logic [7:0] hi, lo, fr, input int win, exp);
    int c;
    host.wr(1'b0, 3'h4, {p, 7'h00});
    host.wr(1'b1, 3'h1, hi);
    host.wr(1'b1, 3'h0, lo);
    host.wr(1'b1, 3'h2, fr);
    wait_tick;
    wait_tick;
    c = 0;
    repeat (win)
    begin
      @(posedge clk);
      c += sample_tick;
    end
    chk(c[15:0], exp[15:0]);
    chk(oversample, fr[5:4]);
    $display("t_rate done");
  endtask
  task t_irq;
    for (int f = 0; f < 2; f++)
    begin
      host.wr(1'b0, 3'h2, {7'h00, f[0]});
      for (int i = 0; i < 64; i++)
      begin
        st <= i[5:0];
        @(posedge clk);
        @(posedge clk);
        chk(tx_irq_level, f[0] ? !(i[3] && !i[2] && !i[4]) : (!i[5] || i[4]));
        chk(rx_irq_level, f[0] ? i[0] : i[1]);
      end
    end
    st <= 6'h00;
    $display("t_irq done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_rate(1'b0, 8'h00, 8'h01, 8'h00, 20, 20);
    t_rate(1'b1, 8'h00, 8'h01, 8'h10, 40, 10);
    t_rate(1'b0, 8'h00, 8'h02, 8'h28, 80, 32);
    t_rate(1'b0, 8'h01, 8'h00, 8'h00, 512, 2);
    t_rate(1'b0, 8'h00, 8'h03, 8'h01, 98, 32);
    t_irq;
    finish_test;
  end
endmodule
`default_nettype wire
